// >>> hdl/tone_xcvr_ctrl.sv
// Control and status register bank of the tone transceiver
// Summary of operation
// - Burst-mode bit low runs burst transmit; high disables burst mode.
// - In burst mode with tone output enabled, a transmit write while idle starts a burst then equal pause.
// - End of pause sets transmit-empty and raises interrupt when enabled in tone-pair mode.
// - Call-progress mode doubles burst and pause durations.
// - Without burst, tone lasts while tone output enable stays high.
// - Receiver power bit low enables both receivers, high powers them down.
// - Single-tone bit high selects single tone, low dual tone.
// - Column bit high selects column tone, low row; only with single tone.
// - Transmitter and receiver both down also power down oscillator and reference.
// - Interrupt flag set when transmit-empty or receive-full set; read clears.
// - Transmit-empty only in burst mode; read clears; held clear otherwise.
// - Receive-full set on valid decoded digit; cleared by status read.
// - Delayed steering set on tone absence, cleared on valid tone pair.
// - Transmit-empty sets 100 ms after write, 200 ms in call-progress mode.
// - Route bit sends next control write to secondary register, then back.
// - Call-progress bit high selects call-progress receive, low tone-pair mode.
// - With interrupts in tone-pair mode, open-drain pin pulls low on events.
`timescale 1ns/1ps
`default_nettype none
`include "tone_xcvr_defs.svh"
module tone_xcvr_ctrl
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic srst_i,
   // Host register port
   input wire logic register_select_line_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire tone_xcvr_pkg::nib_t wdata_i,
   output logic [3:0] rdata_o,
   // Receiver events
   input wire logic rx_digit_valid_i,
   input wire tone_xcvr_pkg::nib_t rx_digit_i,
   input wire logic tone_present_i,
   input wire logic tone_absent_i,
   input wire logic cp_square_i,
   // Transmitter and analog control
   output logic tone_on_o,
   output logic [3:0] tx_digit_o,
   output logic single_tone_o,
   output logic column_tone_o,
   output logic receiver_power_down_o,
   output logic call_progress_select_o,
   output logic osc_power_down_o,
   // Open-drain interrupt or progress pin
   output logic interrupt_or_progress_pin_o,
   output logic interrupt_or_progress_pin_oe_o
);
   import tone_xcvr_pkg::*;

   // ************************************
   // State
   // ************************************
   typedef struct packed
   {
      nib_t pri;
      nib_t sec;
      logic route;
      nib_t tx_data;
      nib_t rx_data;
      tx_state_e tx_st;
      logic tx_empty;
      logic rx_full;
      logic dly_steer;
      nib_t rdata;
      logic tone_on;
      logic osc_pd;
      logic pin_oe;
   } ctrl_s;
   ctrl_s q, d;

   logic timer_start;
   logic timer_done;
   logic burst_mode;
   logic irq_flag;

   burst_timer u_timer
   (
      .clk_i(clk_i),
      .srst_i(srst_i),
      .start_i(timer_start),
      .double_i(q.pri[`PRI_CALL_PROG]),
      .done_o(timer_done)
   );

   // ************************************
   // Next state
   // ************************************
   always_comb
   begin
      d = q;
      timer_start = 1'b0;
      burst_mode = ~q.sec[`SEC_BURST_N];
      irq_flag = q.tx_empty | q.rx_full;
      // Register writes
      if (wr_i && register_select_line_i == `RSL_CTRL)
      begin
         if (q.route)
         begin
            d.sec = wdata_i;
            d.route = 1'b0;
         end
         else
         begin
            d.pri = wdata_i;
            d.route = wdata_i[`PRI_ROUTE];
         end
      end
      // Burst sequencer
      unique case (q.tx_st)
         TX_IDLE:
         begin
            if (wr_i && register_select_line_i == `RSL_DATA)
            begin
               d.tx_data = wdata_i;
               if (burst_mode && q.pri[`PRI_TONE_OUT])
               begin
                  timer_start = 1'b1;
                  d.tx_st = TX_BURST;
               end
            end
         end
         TX_BURST:
         begin
            if (timer_done)
            begin
               timer_start = 1'b1;
               d.tx_st = TX_PAUSE;
            end
         end
         TX_PAUSE:
         begin
            if (timer_done)
            begin
               d.tx_st = TX_IDLE;
               d.tx_empty = 1'b1;
            end
         end
         default:
         begin
            d.tx_st = TX_IDLE;
         end
      endcase
      if (!burst_mode || !q.pri[`PRI_TONE_OUT])
      begin
         d.tx_st = TX_IDLE;
      end
      // Tone drive: burst window or held by tone enable
      // Next enable value, so the tone stops in the cycle the oscillator powers down
      d.tone_on = d.pri[`PRI_TONE_OUT] & (burst_mode ? (d.tx_st == TX_BURST) : 1'b1);
      if (!q.pri[`PRI_TONE_OUT])
      begin
         d.tx_data = 4'h0;
      end
      // Receiver events, digit capture disabled while powered down or in call-progress mode
      if (rx_digit_valid_i && !q.sec[`SEC_RX_PD] && !q.pri[`PRI_CALL_PROG])
      begin
         d.rx_data = rx_digit_i;
      end
      if (tone_absent_i)
      begin
         d.dly_steer = 1'b1;
      end
      if (tone_present_i)
      begin
         d.dly_steer = 1'b0;
      end
      // Status and data reads
      d.rdata = 4'h0;
      if (rd_i && register_select_line_i == `RSL_CTRL)
      begin
         d.rdata[`STS_IRQ] = irq_flag;
         d.rdata[`STS_TX_EMPTY] = q.tx_empty;
         d.rdata[`STS_RX_FULL] = q.rx_full;
         d.rdata[`STS_DLY_STEER] = q.dly_steer;
         if (!(q.tx_st == TX_PAUSE && timer_done))
         begin
            d.tx_empty = 1'b0;
         end
         d.rx_full = 1'b0;
      end
      else if (rd_i)
      begin
         d.rdata = q.rx_data;
      end
      // Set wins over read clear
      if (rx_digit_valid_i && !q.sec[`SEC_RX_PD] && !q.pri[`PRI_CALL_PROG])
      begin
         d.rx_full = 1'b1;
      end
      if (!burst_mode)
      begin
         d.tx_empty = 1'b0;
      end
      d.osc_pd = ~d.pri[`PRI_TONE_OUT] & d.sec[`SEC_RX_PD];
      // Open-drain pin: enable low while pulling low
      if (!d.pri[`PRI_IRQ_EN])
      begin
         d.pin_oe = 1'b1;
      end
      else if (d.pri[`PRI_CALL_PROG])
      begin
         d.pin_oe = ~cp_square_i;
      end
      else
      begin
         d.pin_oe = ~(d.tx_empty | d.rx_full);
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         q <= '0;
         q.pri <= `PRI_RST;
         q.sec <= `SEC_RST;
         q.pin_oe <= 1'b1;
      end
      else
      begin
         q <= d;
      end
   end

   // ************************************
   // Outputs
   // ************************************
   assign rdata_o = q.rdata;
   assign tone_on_o = q.tone_on;
   assign tx_digit_o = q.tx_data;
   assign single_tone_o = q.sec[`SEC_SINGLE];
   assign column_tone_o = q.sec[`SEC_COLUMN] & q.sec[`SEC_SINGLE];
   assign receiver_power_down_o = q.sec[`SEC_RX_PD];
   assign call_progress_select_o = q.pri[`PRI_CALL_PROG];
   assign osc_power_down_o = q.osc_pd;
   assign interrupt_or_progress_pin_o = 1'b0;
   assign interrupt_or_progress_pin_oe_o = q.pin_oe;
endmodule : tone_xcvr_ctrl
`default_nettype wire

// >>> hdl/tone_xcvr_defs.svh
// Offsets, field positions, reset values and timing counts of the tone transceiver control block
`ifndef TONE_XCVR_DEFS_SVH
`define TONE_XCVR_DEFS_SVH

// Register select line decode
`define RSL_DATA 1'h0
`define RSL_CTRL 1'h1

// Primary control fields
`define PRI_TONE_OUT 0
`define PRI_CALL_PROG 1
`define PRI_IRQ_EN 2
`define PRI_ROUTE 3

// Secondary control fields
`define SEC_BURST_N 0
`define SEC_RX_PD 1
`define SEC_SINGLE 2
`define SEC_COLUMN 3

// Status fields
`define STS_IRQ 0
`define STS_TX_EMPTY 1
`define STS_RX_FULL 2
`define STS_DLY_STEER 3

// Reset values
`define PRI_RST 4'h0
`define SEC_RST 4'h0

// Timing: burst and pause each 50 ms, 100 ms total; doubled in call-progress mode
`define CLK_HZ 20000000
`define BURST_MS 50
`define BURST_CYC ((`CLK_HZ / 1000) * `BURST_MS)

`endif

// >>> hdl/tone_xcvr_pkg.sv
// Types shared by the tone transceiver control block
package tone_xcvr_pkg;
   typedef logic [3:0] nib_t;
   typedef enum logic [1:0] {
      TX_IDLE = 2'b00,
      TX_BURST = 2'b01,
      TX_PAUSE = 2'b10
   } tx_state_e;
endpackage : tone_xcvr_pkg

// >>> hdl/burst_timer.sv
// Down counter timing one burst or pause interval
`timescale 1ns/1ps
`default_nettype none
`include "tone_xcvr_defs.svh"
module burst_timer
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic srst_i,
   // Control
   input wire logic start_i,
   input wire logic double_i,
   // Status
   output logic done_o
);
   localparam int unsigned BASE = `BURST_CYC;
   typedef struct packed
   {
      logic [22:0] cnt;
      logic run;
      logic done;
   } timer_s;
   timer_s q, d;

   always_comb
   begin
      d = q;
      d.done = 1'b0;
      if (start_i)
      begin
         d.cnt = double_i ? 23'(2 * BASE - 1) : 23'(BASE - 1);
         d.run = 1'b1;
      end
      else if (q.run)
      begin
         if (q.cnt == 23'h0)
         begin
            d.run = 1'b0;
            d.done = 1'b1;
         end
         else
         begin
            d.cnt = q.cnt - 23'h1;
         end
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end

   assign done_o = q.done;
endmodule : burst_timer
`default_nettype wire

// >>> verif/tone_xcvr_ctrl_asserts.sv
// Port assertions of the tone transceiver control block
`timescale 1ns/1ps
`default_nettype none
module tone_xcvr_ctrl_asserts
(
   // Clock, reset and inputs
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic register_select_line_i,
   input wire logic rd_i,
   input wire logic rx_digit_valid_i,
   input wire logic tone_present_i,
   input wire logic tone_absent_i,
   // Outputs
   input wire logic [3:0] rdata_o,
   input wire logic tone_on_o,
   input wire logic single_tone_o,
   input wire logic column_tone_o,
   input wire logic receiver_power_down_o,
   input wire logic call_progress_select_o,
   input wire logic osc_power_down_o,
   input wire logic interrupt_or_progress_pin_o,
   input wire logic interrupt_or_progress_pin_oe_o
);
   wire sr = rd_i & register_select_line_i;
   wire rx_ok = rx_digit_valid_i & ~receiver_power_down_o & ~call_progress_select_o;
   default clocking @(posedge clk_i); endclocking
   default disable iff (srst_i);
   AST_IRQ_SUM: assert property (sr |=> rdata_o[0] == (rdata_o[1] | rdata_o[2]))
      else $error("irq flag mismatch");
   AST_RX_SET: assert property (rx_ok ##1 !rd_i ##1 sr |=> rdata_o[2])
      else $error("receive flag not set");
   AST_RX_CLR: assert property (sr && !rx_digit_valid_i ##1 !rx_digit_valid_i ##1 sr |=> !rdata_o[2])
      else $error("receive flag not cleared");
   AST_STEER_SET: assert property (tone_absent_i && !tone_present_i ##1 !tone_present_i ##1 sr |=> rdata_o[3])
      else $error("steering flag not set");
   AST_STEER_CLR: assert property (tone_present_i ##1 !tone_absent_i ##1 sr |=> !rdata_o[3])
      else $error("steering flag not cleared");
   AST_COLUMN: assert property (column_tone_o |-> single_tone_o)
      else $error("column without single tone");
   AST_OSC: assert property (osc_power_down_o |-> receiver_power_down_o && !tone_on_o)
      else $error("oscillator down too early");
   AST_PIN_LOW: assert property (interrupt_or_progress_pin_o == 1'b0)
      else $error("pin drives high");
   cover property (sr ##1 rdata_o[2]);
   cover property (osc_power_down_o);
   cover property ($fell(interrupt_or_progress_pin_oe_o));
endmodule : tone_xcvr_ctrl_asserts
bind tone_xcvr_ctrl tone_xcvr_ctrl_asserts u_chk (.*);
`default_nettype wire

// >>> verif/tone_host.sv
// Host processor model on the register port
`timescale 1ns/1ps
`default_nettype none
module tone_host
(
   // Clock and read data
   input wire logic clk_i,
   input wire logic [3:0] rdata_i,
   // Strobes and write data
   output logic rs_o = 1'b0,
   output logic wr_o = 1'b0,
   output logic rd_o = 1'b0,
   output logic [3:0] wdata_o = 4'h0
);
   // One access, released select and data lines show inverted values, strobes go low
   task automatic acc(input logic s, input logic w, input logic [3:0] d, output logic [3:0] q);
      @(posedge clk_i);
      rs_o <= s;
      wr_o <= w;
      rd_o <= !w;
      wdata_o <= d;
      @(posedge clk_i);
      wr_o <= 1'b0;
      rd_o <= 1'b0;
      rs_o <= ~s;
      wdata_o <= ~d;
      #1;
      q = rdata_i;
   endtask : acc
   task automatic init(output logic [3:0] q);
      logic [3:0] x;
      acc(1'b1, 1'b0, 4'h0, x);
      acc(1'b1, 1'b1, 4'h0, x);
      acc(1'b1, 1'b1, 4'h0, x);
      acc(1'b1, 1'b1, 4'h8, x);
      acc(1'b1, 1'b1, 4'h0, x);
      acc(1'b1, 1'b0, 4'h0, q);
   endtask : init
endmodule : tone_host
`default_nettype wire

// >>> verif/tone_xcvr_ctrl_tb_top.sv
// Self-checking testbench of the tone transceiver control block
`timescale 1ns/1ps
`default_nettype none
module tone_xcvr_ctrl_tb_top;
   import tone_xcvr_pkg::*;
   logic clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic rs, wr, rd, ton, sgl, col, rpd, cpo, osc, pin, pin_oe;
   logic dv = 1'b0;
   logic tp = 1'b0;
   logic ta = 1'b0;
   logic cps = 1'b0;
   nib_t wdata, dig;
   logic [3:0] rdata, txd, q;
   int fail_count = 0;
   int checks_done = 0;
   always #25 clk_i = ~clk_i;
   tone_host i_host (.clk_i(clk_i), .rdata_i(rdata), .rs_o(rs), .wr_o(wr), .rd_o(rd), .wdata_o(wdata));
   tone_xcvr_ctrl i_dut (.clk_i(clk_i), .srst_i(srst_i), .register_select_line_i(rs), .wr_i(wr),
      .rd_i(rd), .wdata_i(wdata), .rdata_o(rdata), .rx_digit_valid_i(dv), .rx_digit_i(dig),
      .tone_present_i(tp), .tone_absent_i(ta), .cp_square_i(cps), .tone_on_o(ton), .tx_digit_o(txd),
      .single_tone_o(sgl), .column_tone_o(col), .receiver_power_down_o(rpd),
      .call_progress_select_o(cpo), .osc_power_down_o(osc), .interrupt_or_progress_pin_o(pin),
      .interrupt_or_progress_pin_oe_o(pin_oe));
   task automatic chk(input logic [3:0] got, input logic [3:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         fail_count++;
         $display("Error at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic w(input logic s, input logic [3:0] d);
      i_host.acc(s, 1'b1, d, q);
      @(posedge clk_i);
      #1;
   endtask : w
   task automatic r(input logic s);
      i_host.acc(s, 1'b0, 4'h0, q);
   endtask : r
   task automatic ev(input logic [2:0] e, input logic [3:0] d);
      @(posedge clk_i);
      {dv, tp, ta} <= e;
      dig <= d;
      @(posedge clk_i);
      {dv, tp, ta} <= 3'h0;
      dig <= ~d;
   endtask : ev
   task automatic t_cfg();
      logic [3:0] t [4] = '{4'h2, 4'h4, 4'hc, 4'h8};
      i_host.init(q);
      chk(q, 4'h0);
      for (int i = 0; i < 4; i++)
      begin
         w(1'b1, 4'h8);
         w(1'b1, t[i]);
         chk({1'b0, rpd, sgl, col}, {1'b0, t[i][1], t[i][2], t[i][3] & t[i][2]});
      end
      w(1'b1, 4'h2);
      chk({cpo, rpd, sgl, col}, 4'h8);
      w(1'b1, 4'h8);
      w(1'b1, 4'h2);
      chk({3'h0, osc}, 4'h1);
      w(1'b1, 4'h9);
      chk({3'h0, osc}, 4'h0);
      w(1'b1, 4'h0);
      $display("config done");
   endtask : t_cfg
   task automatic t_flags();
      w(1'b1, 4'h4);
      ev(3'h4, 4'h9);
      r(1'b1);
      chk(q, 4'h5);
      ev(3'h4, 4'h3);
      @(posedge clk_i);
      #1;
      chk({3'h0, pin_oe}, 4'h0);
      r(1'b0);
      chk(q, 4'h3);
      r(1'b1);
      chk(q, 4'h5);
      r(1'b1);
      chk(q, 4'h0);
      chk({3'h0, pin_oe}, 4'h1);
      ev(3'h1, 4'h0);
      r(1'b1);
      chk(q, 4'h8);
      ev(3'h2, 4'h0);
      r(1'b1);
      chk(q, 4'h0);
      w(1'b1, 4'h6);
      chk({3'h0, pin_oe}, 4'h1);
      @(posedge clk_i);
      cps <= 1'b1;
      @(posedge clk_i);
      #1;
      chk({3'h0, pin_oe}, 4'h0);
      ev(3'h4, 4'h5);
      r(1'b1);
      chk(q, 4'h0);
      r(1'b0);
      chk(q, 4'h3);
      @(posedge clk_i);
      cps <= 1'b0;
      $display("flags done");
   endtask : t_flags
   task automatic t_burst();
      w(1'b1, 4'h1);
      w(1'b0, 4'h7);
      chk({ton, txd[2:0]}, 4'hf);
      r(1'b1);
      chk(q, 4'h0);
      w(1'b1, 4'h9);
      w(1'b1, 4'h1);
      chk({3'h0, ton}, 4'h1);
      w(1'b1, 4'h0);
      chk({ton, txd[2:0]}, 4'h0);
      r(1'b1);
      chk(q, 4'h0);
      $display("burst done");
   endtask : t_burst
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : report_and_stop
   initial
   begin
      dig = 4'h0;
      repeat (4) @(posedge clk_i);
      srst_i <= 1'b0;
      t_cfg();
      t_flags();
      t_burst();
      report_and_stop();
   end
endmodule : tone_xcvr_ctrl_tb_top
`default_nettype wire
